// ===== fault_log_pkg.sv
package fault_log_pkg;

	// ==========================================================
	// Record framing constants
	// ==========================================================
	// Byte count sent ahead of the record
	localparam logic [7:0] BYTE_COUNT = 8'hFF;
	// Record index holding the stored loop pointer
	localparam logic [7:0] PTR_INDEX = 8'h00;
	// First cyclic byte, also the preamble length
	localparam logic [7:0] CYCLIC_FIRST = 8'h48;
	// Last record byte with valid fault data
	localparam logic [7:0] LAST_VALID = 8'hED;
	// Last reserved byte, end of the record
	localparam logic [7:0] RECORD_LAST = 8'hFE;
	// Value returned for reserved bytes
	localparam logic [7:0] FILLER = 8'h00;
	// Offset between record index and host byte number
	localparam logic [7:0] HOST_BASE = 8'h01;

	// ==========================================================
	// Telemetry loop layout
	// ==========================================================
	// Highest loop position (loop is this plus one long)
	localparam logic [5:0] LOOP_MAX = 6'h2D;
	// Bytes per output channel
	localparam logic [5:0] CH_BYTES = 6'h05;
	// Start of the input voltage group
	localparam logic [5:0] VIN_POS = 6'h0A;
	// Start of channels 2-3
	localparam logic [5:0] GRP_B_POS = 6'h0D;
	// Start of the temperature group
	localparam logic [5:0] TEMP_POS = 6'h17;
	// Start of channels 4-7
	localparam logic [5:0] GRP_C_POS = 6'h1A;
	// First channel numbers of the later groups
	localparam logic [2:0] GRP_B_CH = 3'h2;
	localparam logic [2:0] GRP_C_CH = 3'h4;

	// ==========================================================
	// Types
	// ==========================================================
	// Which part of the block read a byte belongs to
	typedef enum logic [1:0] {
		KIND_COUNT = 2'h0,
		KIND_PREAMBLE = 2'h1,
		KIND_CYCLIC = 2'h2,
		KIND_RESERVED = 2'h3
	} kind_t;

	// Telemetry field held by a cyclic byte
	typedef enum logic [3:0] {
		FLD_READ_LO = 4'h0,
		FLD_READ_HI = 4'h1,
		FLD_STAT_OUT = 4'h2,
		FLD_STAT_MFR = 4'h3,
		FLD_STAT_MFR2 = 4'h4,
		FLD_VIN_LO = 4'h5,
		FLD_VIN_HI = 4'h6,
		FLD_VIN_STAT = 4'h7,
		FLD_TEMP_LO = 4'h8,
		FLD_TEMP_HI = 4'h9,
		FLD_TEMP_STAT = 4'hA,
		FLD_NONE = 4'hF
	} field_t;

	// One returned byte with its decode
	typedef struct packed {
		logic [7:0] data;
		logic [7:0] index;
		logic [7:0] host_num;
		kind_t kind;
		logic [5:0] position;
		field_t field;
		logic [2:0] channel;
	} out_byte_t;

endpackage : fault_log_pkg

// ===== fault_log_block_readout.sv
`timescale 1ns/1ps
module fault_log_block_readout (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic start,
	output logic [7:0] rec_addr,
	input wire logic [7:0] rec_data,
	output logic out_valid,
	input wire logic out_ready,
	output fault_log_pkg::out_byte_t out_byte,
	output logic busy
);

	// ==========================================================
	// Declarations
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BODY = 3'b010,
		ST_DRAIN = 3'b100
	} state_t;

	state_t state_reg; // Sequencer state
	logic [7:0] idx_reg; // Next record index to load
	logic [5:0] ptr_reg; // Pointer caught from byte zero
	logic [5:0] pos_reg; // Position of last cyclic byte
	logic out_valid_reg; // Output byte holds data
	fault_log_pkg::out_byte_t out_reg; // Output byte
	logic adv; // Output slot free this cycle
	logic load; // A record byte is loaded now
	logic [5:0] ptr_eff; // Pointer clamped into the loop
	logic [5:0] pos_next; // Position for the byte loaded now
	fault_log_pkg::kind_t kind_next; // Region of the byte loaded
	fault_log_pkg::field_t fld_next; // Field of the byte loaded
	logic [2:0] ch_next; // Channel of the byte loaded
	logic [6:0] dec_next; // Channel and field code of the byte loaded

	// ==========================================================
	// Loop layout decode
	// ==========================================================
	// Splits a loop position into channel and field
	function automatic logic [6:0] decode_pos(input logic [5:0] p);
		logic [5:0] rel;
		logic [2:0] base;
		rel = 6'h00;
		base = 3'h0;
		// Input voltage group sits between channels 1 and 2
		if (p >= fault_log_pkg::VIN_POS && p < fault_log_pkg::GRP_B_POS) begin
			rel = p - fault_log_pkg::VIN_POS;
			return {3'h0, 4'(fault_log_pkg::FLD_VIN_LO) + 4'(rel)};
		end
		// Temperature group sits between channels 3 and 4
		if (p >= fault_log_pkg::TEMP_POS && p < fault_log_pkg::GRP_C_POS) begin
			rel = p - fault_log_pkg::TEMP_POS;
			return {3'h0, 4'(fault_log_pkg::FLD_TEMP_LO) + 4'(rel)};
		end
		if (p < fault_log_pkg::VIN_POS) begin
			rel = p;
		end else if (p < fault_log_pkg::TEMP_POS) begin
			rel = p - fault_log_pkg::GRP_B_POS;
			base = fault_log_pkg::GRP_B_CH;
		end else begin
			rel = p - fault_log_pkg::GRP_C_POS;
			base = fault_log_pkg::GRP_C_CH;
		end
		// Five bytes per channel: low, high, status, mfr, mfr2
		return {base + 3'(rel / fault_log_pkg::CH_BYTES),
			4'(rel % fault_log_pkg::CH_BYTES)};
	endfunction : decode_pos

	// ==========================================================
	// Next byte selection
	// ==========================================================
	// Slot frees when empty or when the host takes the byte
	assign adv = !out_valid_reg || out_ready;
	assign load = (state_reg == ST_BODY) && adv;
	assign rec_addr = idx_reg;
	// A corrupt pointer beyond the loop is held at the top
	// 46-byte loop bound
	assign ptr_eff = (ptr_reg > fault_log_pkg::LOOP_MAX) ?
		fault_log_pkg::LOOP_MAX : ptr_reg;

	// Region, position and field of the byte being loaded
	always_comb begin
		kind_next = fault_log_pkg::KIND_PREAMBLE;
		pos_next = 6'h00;
		fld_next = fault_log_pkg::FLD_NONE;
		ch_next = 3'h0;
		dec_next = 7'h00;
		if (idx_reg < fault_log_pkg::CYCLIC_FIRST) begin
			kind_next = fault_log_pkg::KIND_PREAMBLE;
		end else if (idx_reg > fault_log_pkg::LAST_VALID) begin
			kind_next = fault_log_pkg::KIND_RESERVED;
		end else begin
			kind_next = fault_log_pkg::KIND_CYCLIC;
			if (idx_reg == fault_log_pkg::CYCLIC_FIRST) begin
				pos_next = ptr_eff;
			end else if (pos_reg == 6'h00) begin
				pos_next = fault_log_pkg::LOOP_MAX;
			end else begin
				pos_next = pos_reg - 6'h01;
			end
			dec_next = decode_pos(pos_next);
			ch_next = dec_next[6:4];
			// Field code goes back through a cast to the enum type
			fld_next = fault_log_pkg::field_t'(dec_next[3:0]);
		end
	end

	// ==========================================================
	// Sequencer and output valid
	// ==========================================================
	// Count byte first, then record bytes 0..254, then drain
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= ST_IDLE;
			out_valid_reg <= 1'b0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						state_reg <= ST_BODY;
						out_valid_reg <= 1'b1;
					end
				end
				ST_BODY: begin
					if (adv) begin
						out_valid_reg <= 1'b1;
						if (idx_reg == fault_log_pkg::RECORD_LAST) begin
							state_reg <= ST_DRAIN;
						end
					end
				end
				ST_DRAIN: begin
					// Last byte taken: read complete
					if (out_ready) begin
						state_reg <= ST_IDLE;
						out_valid_reg <= 1'b0;
					end
				end
			endcase
		end
	end

	// ==========================================================
	// Record index
	// ==========================================================
	// Index restarts at every block read
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			idx_reg <= 8'h00;
		end else if (state_reg == ST_IDLE) begin
			idx_reg <= fault_log_pkg::PTR_INDEX;
		end else if (load && idx_reg != fault_log_pkg::RECORD_LAST) begin
			idx_reg <= idx_reg + 8'h01;
		end
	end

	// ==========================================================
	// Pointer capture and position tracking
	// ==========================================================
	// pointer from byte zero
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ptr_reg <= 6'h00;
		end else if (load && idx_reg == fault_log_pkg::PTR_INDEX) begin
			ptr_reg <= rec_data[5:0];
		end
	end

	// Position of the last cyclic byte handed out
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pos_reg <= 6'h00;
		end else if (load && kind_next == fault_log_pkg::KIND_CYCLIC) begin
			pos_reg <= pos_next;
		end
	end

	// ==========================================================
	// Output byte register
	// ==========================================================
	// Data is registered so the host sees a steady byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_reg <= '0;
		end else if (state_reg == ST_IDLE && start) begin
			out_reg <= '0;
			out_reg.data <= fault_log_pkg::BYTE_COUNT;
			out_reg.kind <= fault_log_pkg::KIND_COUNT;
			out_reg.field <= fault_log_pkg::FLD_NONE;
		end else if (load) begin
			out_reg.data <= (kind_next == fault_log_pkg::KIND_RESERVED) ?
				fault_log_pkg::FILLER : rec_data;
			out_reg.index <= idx_reg;
			out_reg.host_num <= idx_reg + fault_log_pkg::HOST_BASE;
			out_reg.kind <= kind_next;
			out_reg.position <= pos_next;
			out_reg.field <= fld_next;
			out_reg.channel <= ch_next;
		end
	end

	assign out_valid = out_valid_reg;
	assign out_byte = out_reg;
	assign busy = (state_reg != ST_IDLE);

	// ==========================================================
	// Checks
	// ==========================================================
	// Properties watch the outputs as the host sees them
	AST_COUNT_FIRST: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		state_reg == ST_IDLE && start |=> out_valid &&
		out_byte.kind == fault_log_pkg::KIND_COUNT &&
		out_byte.data == fault_log_pkg::BYTE_COUNT)
		else $error("count byte not first");

	AST_PTR_NEXT: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_ready && out_byte.kind == fault_log_pkg::KIND_COUNT
		|=> out_valid && out_byte.index == fault_log_pkg::PTR_INDEX &&
		out_byte.data[5:0] == ptr_reg)
		else $error("pointer byte not after count");

	AST_PREAMBLE: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind != fault_log_pkg::KIND_COUNT &&
		out_byte.index < fault_log_pkg::CYCLIC_FIRST |->
		out_byte.kind == fault_log_pkg::KIND_PREAMBLE)
		else $error("preamble byte misclassified");

	AST_CYC_START: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.index == fault_log_pkg::CYCLIC_FIRST &&
		out_byte.kind == fault_log_pkg::KIND_CYCLIC |->
		out_byte.position == ptr_eff)
		else $error("byte 72 not at pointer position");

	AST_DESCEND: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_ready &&
		out_byte.kind == fault_log_pkg::KIND_CYCLIC &&
		out_byte.index < fault_log_pkg::LAST_VALID |=>
		out_byte.position == (($past(out_byte.position) == 6'h00) ?
		fault_log_pkg::LOOP_MAX : $past(out_byte.position) - 6'h01))
		else $error("cyclic position did not descend");

	AST_LAST_VALID: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind == fault_log_pkg::KIND_CYCLIC |->
		out_byte.index >= fault_log_pkg::CYCLIC_FIRST &&
		out_byte.index <= fault_log_pkg::LAST_VALID)
		else $error("cyclic byte outside 72..237");

	AST_FILLER: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind == fault_log_pkg::KIND_RESERVED |->
		out_byte.data == fault_log_pkg::FILLER &&
		out_byte.index > fault_log_pkg::LAST_VALID)
		else $error("reserved byte not filler");

	AST_HOST_NUM: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind != fault_log_pkg::KIND_COUNT |->
		out_byte.host_num == out_byte.index + fault_log_pkg::HOST_BASE)
		else $error("host number not index plus one");

	AST_LOOP_RANGE: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid |-> out_byte.position <= fault_log_pkg::LOOP_MAX)
		else $error("position beyond loop");

	AST_VIN_HI: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind == fault_log_pkg::KIND_CYCLIC &&
		out_byte.position == 6'h0B |->
		out_byte.field == fault_log_pkg::FLD_VIN_HI)
		else $error("position 11 not input high");

	AST_CH1_MFR2: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind == fault_log_pkg::KIND_CYCLIC &&
		out_byte.position == 6'h09 |-> out_byte.channel == 3'h1 &&
		out_byte.field == fault_log_pkg::FLD_STAT_MFR2)
		else $error("position 9 not ch1 mfr2");

	// A stalled host must see the same byte, or its count slips
	AST_STALL_HOLD: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && !out_ready |=> out_valid && $stable(out_byte))
		else $error("byte changed while host stalled");

	AST_RESERVED_TAIL: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_byte.kind != fault_log_pkg::KIND_COUNT &&
		out_byte.index > fault_log_pkg::LAST_VALID |->
		out_byte.kind == fault_log_pkg::KIND_RESERVED)
		else $error("byte past last valid not reserved");

	// Read length is fixed: the last reserved byte ends it
	AST_READ_END: assert property (
		@(posedge sys_clk) disable iff (!reset_n)
		out_valid && out_ready &&
		out_byte.kind == fault_log_pkg::KIND_RESERVED &&
		out_byte.index == fault_log_pkg::RECORD_LAST |=>
		!busy && !out_valid)
		else $error("read did not end after last byte");

endmodule : fault_log_block_readout

// ===== host_sink.sv
`timescale 1ns/1ps
// ==========================================================
// Host side of the block read: takes bytes, may stall
// ==========================================================
module host_sink (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic slow,
	output logic out_ready
);
	// Ready moves just after the edge; slow mode withholds it at random
	// so the readout must hold its byte across stalls
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			out_ready <= 1'b0;
		end else begin
			// host takes one byte per ready edge, counted from one
			out_ready <= #1 slow ? 1'($urandom_range(0, 1)) : 1'b1;
		end
	end
endmodule : host_sink

// ===== testbench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; \
	if ((got) !== (ex)) begin failures++; \
	$display("unexpected %s exp %0h got %0h", nm, ex, got); end end
// ==========================================================
// Self-checking bench for the fault record readout
// ==========================================================
module testbench;
	logic sys_clk = 1'b0; // 250 MHz
	logic reset_n = 1'b0; // Active-low reset
	logic start = 1'b0; // Read request
	logic slow = 1'b0; // Host stall mode
	logic [7:0] rec_addr; // Index wanted by the readout
	logic [7:0] rec_data; // Record byte at that index
	logic out_valid;
	logic out_ready;
	logic busy;
	fault_log_pkg::out_byte_t out_byte;
	logic [7:0] mem [0:254]; // Stored fault record
	fault_log_pkg::out_byte_t exp_q [$]; // Expected bytes, oldest first
	fault_log_pkg::out_byte_t e; // Byte under comparison
	int failures = 0;
	int total_checks = 0;

	// Clock
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	// Memory answers combinationally
	assign rec_data = mem[rec_addr];

	fault_log_block_readout u_fault_log_block_readout (.sys_clk(sys_clk),
		.reset_n(reset_n), .start(start), .rec_addr(rec_addr),
		.rec_data(rec_data), .out_valid(out_valid), .out_ready(out_ready),
		.out_byte(out_byte), .busy(busy));
	host_sink u_host_sink (.sys_clk(sys_clk), .reset_n(reset_n),
		.slow(slow), .out_ready(out_ready));

	// Expected decode of record index i for loop pointer ptr
	function automatic fault_log_pkg::out_byte_t exp_byte(int i, int ptr);
		fault_log_pkg::out_byte_t x;
		int p;
		int q;
		x = '0;
		x.index = 8'(i);
		x.host_num = 8'(i + 1);
		// Offset keeps the modulo positive; wraps 0 to 45
		p = (ptr - i + 72 + 184) % 46;
		q = p < 10 ? p : p < 23 ? p - 13 : p - 26;
		if (i < 72) begin
			x.kind = fault_log_pkg::KIND_PREAMBLE;
			x.data = mem[i];
		end else if (i <= 237) begin
			x.kind = fault_log_pkg::KIND_CYCLIC;
			x.data = mem[i];
			x.position = 6'(p);
			if (p < 10 || (p >= 13 && p < 23) || p >= 26) begin
				x.field = fault_log_pkg::field_t'(4'(q % 5));
				x.channel = 3'(q / 5 + (p < 10 ? 0 : p < 23 ? 2 : 4));
			end else begin
				x.field = fault_log_pkg::field_t'(4'(p < 13 ? p - 5 : p - 15));
			end
		end else begin
			x.kind = fault_log_pkg::KIND_RESERVED;
			x.data = fault_log_pkg::FILLER;
		end
		return x;
	endfunction : exp_byte

	// Close the run with counts and verdict
	task automatic wrap_up;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up

	// One full block read; a second start mid-read must be ignored
	task automatic run_read(input logic [7:0] first, input logic mode);
		int n;
		int ptr;
		fault_log_pkg::out_byte_t c; // Count byte note
		ptr = first[5:0] > 6'd45 ? 45 : int'(first[5:0]);
		for (n = 0; n < 255; n++) begin
			mem[n] = 8'($urandom);
		end
		mem[0] = first;
		slow = mode;
		c = '0;
		c.kind = fault_log_pkg::KIND_COUNT;
		c.data = fault_log_pkg::BYTE_COUNT;
		exp_q.push_back(c);
		for (n = 0; n < 255; n++) begin
			exp_q.push_back(exp_byte(n, ptr));
		end
		start = 1'b1;
		@(posedge sys_clk);
		#1;
		`CHK("busy", 1'b1, busy);
		// First pass of the loop lowers start; one write per time step
		n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			start = (n == 20);
			@(posedge sys_clk);
			#1 n++;
		end
		if (n >= 4000) begin
			failures++;
			wrap_up();
		end
		// read ends after byte 254 with nothing left over
		`CHK("left over", 0, exp_q.size());
		`CHK("valid at end", 1'b0, out_valid);
		$display("test pointer %0d slow %0d done", ptr, mode);
	endtask : run_read

	// Reset in mid-read drops the read and clears every output
	task automatic reset_mid_read;
		int n;
		int ptr;
		fault_log_pkg::out_byte_t c; // Count byte note
		ptr = mem[0][5:0] > 6'd45 ? 45 : int'(mem[0][5:0]);
		slow = 1'b0;
		c = '0;
		c.kind = fault_log_pkg::KIND_COUNT;
		c.data = fault_log_pkg::BYTE_COUNT;
		exp_q.push_back(c);
		for (n = 0; n < 255; n++) begin
			exp_q.push_back(exp_byte(n, ptr));
		end
		start = 1'b1;
		@(posedge sys_clk);
		#1 start = 1'b0;
		// Abort once a few dozen bytes have gone out
		repeat (30) @(posedge sys_clk);
		#1 reset_n = 1'b0;
		#1;
		`CHK("valid in reset", 1'b0, out_valid);
		`CHK("busy in reset", 1'b0, busy);
		`CHK("addr in reset", 8'h00, rec_addr);
		`CHK("byte in reset", '0, out_byte);
		// Notes of the dropped read are void
		exp_q.delete();
		repeat (2) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		@(posedge sys_clk);
		#1;
		$display("test reset mid read done");
	endtask : reset_mid_read

	// Compare each taken byte with the oldest note; sampled mid-cycle,
	// where what the next rising edge takes is already settled
	always @(negedge sys_clk) begin
		if (reset_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				`CHK("extra byte", 1'b0, out_valid);
			end else begin
				e = exp_q.pop_front();
				`CHK("kind", e.kind, out_byte.kind);
				`CHK("data", e.data, out_byte.data);
				if (e.kind != fault_log_pkg::KIND_COUNT) begin
					`CHK("index", e.index, out_byte.index);
					`CHK("host_num", e.host_num, out_byte.host_num);
				end
				if (e.kind == fault_log_pkg::KIND_CYCLIC) begin
					`CHK("position", e.position, out_byte.position);
					`CHK("field", e.field, out_byte.field);
					`CHK("channel", e.channel, out_byte.channel);
				end
			end
		end
	end

	// Main sequence
	initial begin
		void'($urandom(16));
		repeat (10) @(posedge sys_clk);
		#1 reset_n = 1'b1;
		@(posedge sys_clk);
		#1;
		// pointer 11 with upper bits set
		run_read(8'hCB, 1'b0);
		// pointer 0 wraps at once, host stalling
		run_read(8'h00, 1'b1);
		run_read(8'h2D, 1'b0);
		run_read(8'h3F, 1'b1);
		// Reset in mid-read, then a fresh read must recover
		reset_mid_read();
		run_read(8'($urandom), 1'b1);
		wrap_up();
	end
endmodule : testbench
